// ---- design/host_mac_vlan_wakeup_filter.sv ----
// receive qualification of the host mac: tag match, length limit, wake
// assumes frame beats and register strobes are synchronous to i_clk_sys
`timescale 1ns/1ps
module host_mac_vlan_wakeup_filter
	import hmac_wake_pkg::*;
#(
	parameter int FDEPTH = FILTER_DEPTH
) (
	input wire logic i_clk_sys, // 100 mhz system clock
	input wire logic i_rst, // async reset, high
	input wire logic i_soft_rst, // digital or soft reset pulse
	input wire reg_req_t i_reg, // register strobes
	output logic [DATA_W-1:0] o_rdata, // read data, cycle after rd
	input wire rx_beat_t i_rx, // frame byte from fabric
	output rx_result_t o_rx_result, // per-frame verdict pulse
	input wire logic [$clog2(FDEPTH)-1:0] i_filter_idx, // filter entry to read
	output logic [DATA_W-1:0] o_filter_word, // selected filter word
	output logic o_power_save, // power saving state
	output logic o_wake, // wake pulse
	output logic o_irq // level interrupt
);

	// ****************************************************************
	// checks and decode
	// ****************************************************************
	if (FDEPTH != FILTER_DEPTH) begin : g_bad_fdepth
		$error("filter depth is fixed by the pointer wrap");
	end

	function automatic logic hit(input logic [ADDR_W-1:0] a,
			input logic [5:0] idx);
		hit = (a == {idx, 2'b00});
	endfunction

	logic wr_tag1;
	logic wr_tag2;
	logic wr_wuff;
	logic wr_wucsr;
	logic wr_stat;
	logic wr_mask;
	logic wr_pwr;

	always_comb begin
		wr_tag1 = i_reg.wr && hit(i_reg.addr, IDX_TAG1);
		wr_tag2 = i_reg.wr && hit(i_reg.addr, IDX_TAG2);
		wr_wuff = i_reg.wr && hit(i_reg.addr, IDX_WUFF);
		wr_wucsr = i_reg.wr && hit(i_reg.addr, IDX_WUCSR);
		wr_stat = i_reg.wr && hit(i_reg.addr, IDX_IRQ_STAT);
		wr_mask = i_reg.wr && hit(i_reg.addr, IDX_IRQ_MASK);
		wr_pwr = i_reg.wr && hit(i_reg.addr, IDX_PWR);
	end

	// ****************************************************************
	// frame byte tracking
	// ****************************************************************
	logic [LEN_W-1:0] cnt_ff;
	logic [LEN_W-1:0] beat_idx;
	logic [LEN_W-1:0] frame_len;
	logic [7:0] tag_hi_ff;
	logic [7:0] tag_lo_ff;
	logic da_group_ff;
	logic [TAG_W-1:0] tag_now;
	logic da_group_now;
	logic tag_present;

	always_comb begin
		beat_idx = i_rx.sof ? '0 : cnt_ff;
		frame_len = (beat_idx == LEN_SAT) ? LEN_SAT : beat_idx + 1'b1;
	end

	// length saturates so a runaway frame still reads as too long
	always_ff @(posedge i_clk_sys or posedge i_rst) begin
		if (i_rst) begin
			cnt_ff <= '0;
		end else if (i_rx.valid) begin
			cnt_ff <= frame_len;
		end
	end

	always_ff @(posedge i_clk_sys or posedge i_rst) begin
		if (i_rst) begin
			tag_hi_ff <= '0;
			tag_lo_ff <= '0;
			da_group_ff <= 1'b0;
		end else if (i_rx.valid) begin
			if (beat_idx == DA_BYTE) begin
				da_group_ff <= i_rx.data[DA_GROUP_BIT];
			end
			if (beat_idx == TAG_HI_BYTE) begin
				tag_hi_ff <= i_rx.data;
			end
			if (beat_idx == TAG_LO_BYTE) begin
				tag_lo_ff <= i_rx.data;
			end
		end
	end

	// the last byte may be a tag or address byte, so look through
	always_comb begin
		tag_now = {tag_hi_ff, tag_lo_ff};
		da_group_now = da_group_ff;
		if (i_rx.valid && beat_idx == TAG_LO_BYTE) begin
			tag_now = {tag_hi_ff, i_rx.data};
		end
		if (i_rx.valid && beat_idx == DA_BYTE) begin
			da_group_now = i_rx.data[DA_GROUP_BIT];
		end
		tag_present = beat_idx >= TAG_LO_BYTE;
	end

	// ****************************************************************
	// tag match and length limit
	// ****************************************************************
	logic [TAG_W-1:0] tag1_ff;
	logic [TAG_W-1:0] tag2_ff;
	logic tag1_hit;
	logic tag2_hit;
	logic [LEN_W-1:0] max_len;
	logic frame_end;
	logic too_long;

	always_comb begin
		frame_end = i_rx.valid && i_rx.eof;
		tag1_hit = tag_present && tag_now == tag1_ff;
		// equal values would match both; the first keeps the frame
		tag2_hit = tag_present && tag_now == tag2_ff
			&& !tag1_hit;
		max_len = LEN_BASE;
		if (tag1_hit) begin
			max_len = LEN_TAG1;
		end else if (tag2_hit) begin
			max_len = LEN_TAG2;
		end
		too_long = frame_len > max_len;
	end

	always_ff @(posedge i_clk_sys or posedge i_rst) begin
		if (i_rst) begin
			o_rx_result <= '0;
		end else begin
			o_rx_result.done <= frame_end;
			if (frame_end) begin
				o_rx_result.tag1 <= tag1_hit;
				o_rx_result.tag2 <= tag2_hit;
				o_rx_result.too_long <= too_long;
				o_rx_result.len <= frame_len;
			end
		end
	end

	// ****************************************************************
	// wake events
	// ****************************************************************
	logic [DATA_W-1:0] wucsr_ff;
	logic ev_frame;
	logic ev_magic;
	logic ev_unicast;
	logic ev_wake;
	logic ev_oversize;

	always_comb begin
		ev_frame = frame_end && i_rx.good && i_rx.filter_hit
			&& wucsr_ff[WUCSR_WAKE_EN];
		ev_magic = frame_end && i_rx.good && i_rx.magic
			&& wucsr_ff[WUCSR_MAGIC_EN];
		ev_unicast = frame_end && i_rx.good && !da_group_now
			&& wucsr_ff[WUCSR_UNICAST];
		ev_wake = ev_frame || ev_magic || ev_unicast;
		ev_oversize = frame_end && too_long;
	end

	// ****************************************************************
	// wake control and status
	// ****************************************************************
	localparam logic [DATA_W-1:0] WUCSR_RW =
		(DATA_W'(1) << WUCSR_UNICAST) | (DATA_W'(1) << WUCSR_WAKE_EN)
		| (DATA_W'(1) << WUCSR_MAGIC_EN);
	localparam logic [DATA_W-1:0] WUCSR_FLAGS =
		(DATA_W'(1) << WUCSR_WAKE_RX) | (DATA_W'(1) << WUCSR_MAGIC_RX);

	logic [DATA_W-1:0] nxt_wucsr;

	always_comb begin
		nxt_wucsr = wucsr_ff;
		if (wr_wucsr) begin
			nxt_wucsr = (i_reg.wdata & WUCSR_RW)
				| (wucsr_ff & WUCSR_FLAGS & ~i_reg.wdata);
		end
		// a frame landing with the clear still sets its flag
		if (ev_frame || ev_unicast) begin
			nxt_wucsr[WUCSR_WAKE_RX] = 1'b1;
		end
		if (ev_magic) begin
			nxt_wucsr[WUCSR_MAGIC_RX] = 1'b1;
		end
	end

	always_ff @(posedge i_clk_sys or posedge i_rst) begin
		if (i_rst) begin
			wucsr_ff <= '0;
		end else if (i_soft_rst) begin
			wucsr_ff <= '0;
		end else begin
			wucsr_ff <= nxt_wucsr;
		end
	end

	// ****************************************************************
	// tag value registers
	// ****************************************************************
	always_ff @(posedge i_clk_sys or posedge i_rst) begin
		if (i_rst) begin
			tag1_ff <= TAG_RESET;
			tag2_ff <= TAG_RESET;
		end else if (i_soft_rst) begin
			tag1_ff <= TAG_RESET;
			tag2_ff <= TAG_RESET;
		end else begin
			if (wr_tag1) begin
				tag1_ff <= i_reg.wdata[TAG_W-1:0];
			end
			if (wr_tag2) begin
				tag2_ff <= i_reg.wdata[TAG_W-1:0];
			end
		end
	end

	// ****************************************************************
	// power saving state
	// ****************************************************************
	// software enters power saving; any qualified wake leaves it
	always_ff @(posedge i_clk_sys or posedge i_rst) begin
		if (i_rst) begin
			o_power_save <= 1'b0;
			o_wake <= 1'b0;
		end else if (i_soft_rst) begin
			o_power_save <= 1'b0;
			o_wake <= 1'b0;
		end else begin
			o_wake <= ev_wake && o_power_save;
			if (ev_wake) begin
				o_power_save <= 1'b0;
			end else if (wr_pwr) begin
				o_power_save <= i_reg.wdata[PWR_SAVE_BIT];
			end
		end
	end

	// ****************************************************************
	// interrupt status and mask
	// ****************************************************************
	logic [IRQ_W-1:0] stat_ff;
	logic [IRQ_W-1:0] mask_ff;
	logic [IRQ_W-1:0] ev_vec;
	logic [IRQ_W-1:0] nxt_stat;

	always_comb begin
		ev_vec = '0;
		ev_vec[IRQ_WAKE_FRAME] = ev_frame;
		ev_vec[IRQ_MAGIC] = ev_magic;
		ev_vec[IRQ_UNICAST] = ev_unicast;
		ev_vec[IRQ_OVERSIZE] = ev_oversize;
		nxt_stat = stat_ff;
		if (wr_stat) begin
			nxt_stat = stat_ff & ~i_reg.wdata[IRQ_W-1:0];
		end
		nxt_stat = nxt_stat | ev_vec;
	end

	always_ff @(posedge i_clk_sys or posedge i_rst) begin
		if (i_rst) begin
			stat_ff <= '0;
			mask_ff <= '0;
		end else if (i_soft_rst) begin
			stat_ff <= '0;
			mask_ff <= '0;
		end else begin
			stat_ff <= nxt_stat;
			if (wr_mask) begin
				mask_ff <= i_reg.wdata[IRQ_W-1:0];
			end
		end
	end

	// follows the status one cycle late so the pin stays a flop
	always_ff @(posedge i_clk_sys or posedge i_rst) begin
		if (i_rst) begin
			o_irq <= 1'b0;
		end else begin
			o_irq <= |(stat_ff & mask_ff);
		end
	end

	// ****************************************************************
	// wake filter store
	// ****************************************************************
	wake_filter_store #(
		.WORD_W(DATA_W),
		.DEPTH(FDEPTH)
	) u_filter (
		.i_clk_sys(i_clk_sys),
		.i_rst(i_rst),
		.i_soft_rst(i_soft_rst),
		.i_wr(wr_wuff),
		.i_wdata(i_reg.wdata),
		.i_rd_idx(i_filter_idx),
		.o_rd_word(o_filter_word),
		.o_wr_ptr()
	);

	// ****************************************************************
	// read port
	// ****************************************************************
	// the filter port is write only and reads as zero, like any hole
	logic [DATA_W-1:0] nxt_rdata;

	always_comb begin
		nxt_rdata = '0;
		if (i_reg.rd) begin
			if (hit(i_reg.addr, IDX_TAG1)) begin
				nxt_rdata[TAG_W-1:0] = tag1_ff;
			end else if (hit(i_reg.addr, IDX_TAG2)) begin
				nxt_rdata[TAG_W-1:0] = tag2_ff;
			end else if (hit(i_reg.addr, IDX_WUCSR)) begin
				nxt_rdata = wucsr_ff;
			end else if (hit(i_reg.addr, IDX_IRQ_STAT)) begin
				nxt_rdata[IRQ_W-1:0] = stat_ff;
			end else if (hit(i_reg.addr, IDX_IRQ_MASK)) begin
				nxt_rdata[IRQ_W-1:0] = mask_ff;
			end else if (hit(i_reg.addr, IDX_PWR)) begin
				nxt_rdata[PWR_SAVE_BIT] = o_power_save;
			end
		end
	end

	always_ff @(posedge i_clk_sys or posedge i_rst) begin
		if (i_rst) begin
			o_rdata <= '0;
		end else begin
			o_rdata <= nxt_rdata;
		end
	end

endmodule

// ---- design/hmac_wake_pkg.sv ----
// constants, field layouts and carriers for the host mac tag and wake block
// assumes one system clock and a synchronous register port
//
// What this block does
// - compare first tag value with frame bytes 13-14; reset value all ones
// - a first-tag frame may be up to 1522 bytes instead of 1518
// - compare second tag value, reset all ones, with frame bytes 13-14
// - a second-tag frame may be up to 1538 bytes instead of 1518
// - equal tag values: first tag wins, limit becomes 1522
// - any reset points the filter write pointer at entry zero; writes advance
// - after eight filter writes the pointer wraps back to entry zero
// - with unicast wake enabled, a global unicast frame ends power saving
// - global unicast means destination address bit zero is zero
// - wake frame received flag, bit 6, set on a valid wake frame
// - magic packet received flag, bit 5, set on a valid magic packet
// - wake frame enable, bit 2, gates wake frame detection
// - magic packet enable, bit 1, gates magic packet detection
package hmac_wake_pkg;

	localparam int ADDR_W = 8;
	localparam int DATA_W = 32;
	localparam int FILTER_DEPTH = 8;

	// ****************************************************************
	// register indices; the byte address is four times the index
	// ****************************************************************
	localparam logic [5:0] IDX_TAG1 = 6'h09;
	localparam logic [5:0] IDX_TAG2 = 6'h0a;
	localparam logic [5:0] IDX_WUFF = 6'h0b;
	localparam logic [5:0] IDX_WUCSR = 6'h0c;
	localparam logic [5:0] IDX_IRQ_STAT = 6'h0d;
	localparam logic [5:0] IDX_IRQ_MASK = 6'h0e;
	localparam logic [5:0] IDX_PWR = 6'h0f;

	// ****************************************************************
	// fields and reset values
	// ****************************************************************
	localparam int TAG_W = 16;
	localparam logic [TAG_W-1:0] TAG_RESET = 16'hffff;
	localparam int WUCSR_UNICAST = 9;
	localparam int WUCSR_WAKE_RX = 6;
	localparam int WUCSR_MAGIC_RX = 5;
	localparam int WUCSR_WAKE_EN = 2;
	localparam int WUCSR_MAGIC_EN = 1;
	localparam int PWR_SAVE_BIT = 0;
	localparam int IRQ_W = 4;
	localparam int IRQ_WAKE_FRAME = 0;
	localparam int IRQ_MAGIC = 1;
	localparam int IRQ_UNICAST = 2;
	localparam int IRQ_OVERSIZE = 3;

	// ****************************************************************
	// frame positions and length limits
	// ****************************************************************
	localparam int LEN_W = 12;
	localparam logic [LEN_W-1:0] DA_BYTE = 12'h000;
	localparam int DA_GROUP_BIT = 0;
	localparam logic [LEN_W-1:0] TAG_HI_BYTE = 12'h00c;
	localparam logic [LEN_W-1:0] TAG_LO_BYTE = 12'h00d;
	localparam logic [LEN_W-1:0] LEN_BASE = 12'h5ee;
	localparam logic [LEN_W-1:0] LEN_TAG1 = 12'h5f2;
	localparam logic [LEN_W-1:0] LEN_TAG2 = 12'h602;
	localparam logic [LEN_W-1:0] LEN_SAT = 12'hfff;

	typedef struct packed {
		logic wr;
		logic rd;
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] wdata;
	} reg_req_t;

	typedef struct packed {
		logic valid;
		logic sof;
		logic eof;
		logic good;
		logic magic;
		logic filter_hit;
		logic [7:0] data;
	} rx_beat_t;

	typedef struct packed {
		logic done;
		logic tag1;
		logic tag2;
		logic too_long;
		logic [LEN_W-1:0] len;
	} rx_result_t;

endpackage

// ---- design/wake_filter_store.sv ----
// eight-word wake filter store written through one auto-incrementing port
// assumes writes arrive as one-cycle strobes on the system clock
`timescale 1ns/1ps
module wake_filter_store
	import hmac_wake_pkg::*;
#(
	parameter int WORD_W = 32,
	parameter int DEPTH = 8
) (
	input wire logic i_clk_sys, // system clock
	input wire logic i_rst, // async reset, high
	input wire logic i_soft_rst, // sync reset pulse
	input wire logic i_wr, // write strobe
	input wire logic [WORD_W-1:0] i_wdata, // word to store
	input wire logic [$clog2(DEPTH)-1:0] i_rd_idx, // entry to read
	output logic [WORD_W-1:0] o_rd_word, // registered entry
	output logic [$clog2(DEPTH)-1:0] o_wr_ptr // next entry written
);
	localparam int PW = $clog2(DEPTH);

	if (DEPTH < 2 || (1 << PW) != DEPTH) begin : g_bad_depth
		$error("filter depth must be a power of two");
	end

	logic [WORD_W-1:0] mem_ff [DEPTH];
	logic [PW-1:0] ptr_ff;

	// power of two depth makes the wrap a plain overflow
	always_ff @(posedge i_clk_sys or posedge i_rst) begin
		if (i_rst) begin
			ptr_ff <= '0;
		end else if (i_soft_rst) begin
			ptr_ff <= '0;
		end else if (i_wr) begin
			ptr_ff <= ptr_ff + 1'b1;
		end
	end

	for (genvar g = 0; g < DEPTH; g++) begin : g_entry
		always_ff @(posedge i_clk_sys or posedge i_rst) begin
			if (i_rst) begin
				mem_ff[g] <= '0;
			end else if (i_wr && ptr_ff == PW'(g)) begin
				mem_ff[g] <= i_wdata;
			end
		end
	end

	always_ff @(posedge i_clk_sys or posedge i_rst) begin
		if (i_rst) begin
			o_rd_word <= '0;
		end else begin
			o_rd_word <= mem_ff[i_rd_idx];
		end
	end

	assign o_wr_ptr = ptr_ff;

endmodule

// ---- bench/hmac_wake_asserts.sv ----
// checker for the read port, frame verdicts and wake outputs
// assumes it is bound to the top module and sees only its ports
`timescale 1ns/1ps
module hmac_wake_asserts
	import hmac_wake_pkg::*;
(
	input wire logic i_clk_sys, // system clock
	input wire logic i_rst, // async reset, high
	input wire reg_req_t i_reg, // register strobes
	input wire logic [DATA_W-1:0] o_rdata, // read data
	input wire rx_beat_t i_rx, // frame beat
	input wire rx_result_t o_rx_result, // frame verdict
	input wire logic o_power_save, // power state
	input wire logic o_wake // wake pulse
);
	default clocking @(posedge i_clk_sys); endclocking
	default disable iff (i_rst);
	logic [LEN_W-1:0] lim;
	// ****
	// limit of the frame just judged; first tag is tested first
	// ****
	assign lim = o_rx_result.tag1 ? LEN_TAG1 :
		(o_rx_result.tag2 ? LEN_TAG2 : LEN_BASE);
	rdata_idle_a: assert property (!i_reg.rd |=> o_rdata == '0)
		else $error("read data not idle");
	rdata_resv_a: assert property (i_reg.rd &&
		i_reg.addr inside {8'h24, 8'h28} |=> o_rdata[31:TAG_W] == '0)
		else $error("reserved tag bits read nonzero");
	port_read_a: assert property (i_reg.rd &&
		(i_reg.addr == 8'h2c || i_reg.addr > 8'h3c) |=> o_rdata == '0)
		else $error("write-only or unmapped read nonzero");
	done_cause_a: assert property (i_rx.valid && i_rx.eof |=>
		o_rx_result.done) else $error("no verdict after frame end");
	done_once_a: assert property (!(i_rx.valid && i_rx.eof) |=>
		!o_rx_result.done) else $error("verdict without frame end");
	len_limit_a: assert property (o_rx_result.done |->
		o_rx_result.too_long == (o_rx_result.len > lim))
		else $error("oversize verdict wrong");
	tag_prio_a: assert property (o_rx_result.done &&
		o_rx_result.tag1 |-> !o_rx_result.tag2)
		else $error("both tags reported");
	wake_src_a: assert property (o_wake |->
		o_rx_result.done && $past(o_power_save))
		else $error("wake without frame in power save");
	wake_leave_a: assert property (o_wake |-> !o_power_save)
		else $error("power save kept after wake");
	cover property (o_wake);
	cover property (o_rx_result.done && o_rx_result.too_long);
	cover property (o_rx_result.done && o_rx_result.tag2);
endmodule

bind host_mac_vlan_wakeup_filter hmac_wake_asserts chk_u (.i_clk_sys,
	.i_rst, .i_reg, .o_rdata, .i_rx, .o_rx_result, .o_power_save, .o_wake);

// ---- bench/fabric_model.sv ----
// switch fabric side model feeding received frames one byte a cycle
// assumes the bench calls send from one process at a time
`timescale 1ns/1ps
module fabric_model
	import hmac_wake_pkg::*;
(
	input wire logic i_clk_sys, // system clock
	output rx_beat_t o_rx // frame beat to the mac
);
	initial o_rx = '0;
	task automatic send(input int len, input logic [15:0] tag,
		input logic da0, input logic [2:0] fl);
		for (int i = 0; i < len; i++) begin
			@(posedge i_clk_sys);
			o_rx.valid <= 1'b1;
			o_rx.sof <= (i == 0);
			o_rx.eof <= (i == len - 1);
			{o_rx.good, o_rx.magic, o_rx.filter_hit} <= fl;
			o_rx.data <= (i == 0) ? {7'h00, da0} :
				(i == 12) ? tag[15:8] :
				(i == 13) ? tag[7:0] : i[7:0];
		end
		@(posedge i_clk_sys);
		o_rx.valid <= 1'b0;
		o_rx.eof <= 1'b0;
		// idle data flips so a stale byte never passes for a held one
		o_rx.data <= ~o_rx.data;
	endtask
endmodule

// ---- bench/host_mac_vlan_wakeup_filter_tb.sv ----
// self-checking bench for tag match, length limit, filter and wake
// assumes the package, fabric model and checker compile before it
`timescale 1ns/1ps
module host_mac_vlan_wakeup_filter_tb
	import hmac_wake_pkg::*;
;
	logic i_clk_sys = 1'b0;
	logic i_rst = 1'b1;
	logic i_soft_rst = 1'b0;
	reg_req_t i_reg = '0;
	rx_beat_t rx;
	rx_result_t res;
	logic [2:0] fidx = 3'h0;
	logic [DATA_W-1:0] rdata;
	logic [DATA_W-1:0] fword;
	logic ps;
	logic wake;
	logic irq;
	logic [31:0] v;
	int mismatches = 0;
	int check_count = 0;

	host_mac_vlan_wakeup_filter dut_u (.i_clk_sys, .i_rst, .i_soft_rst,
		.i_reg, .o_rdata(rdata), .i_rx(rx), .o_rx_result(res),
		.i_filter_idx(fidx), .o_filter_word(fword), .o_power_save(ps),
		.o_wake(wake), .o_irq(irq));
	fabric_model m_u (.i_clk_sys, .o_rx(rx));

	// ****
	// shared tasks
	// ****
	task automatic check(input string n, input logic [31:0] got, exp);
		check_count++;
		if (got !== exp) begin
			mismatches++;
			$display("MISMATCH %s exp %h got %h", n, exp, got);
		end
	endtask
	task automatic close_out;
		if (mismatches == 0 && check_count > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge i_clk_sys);
		i_reg <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
		@(posedge i_clk_sys);
		i_reg.wr <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a);
		@(posedge i_clk_sys);
		i_reg <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 32'h0};
		@(posedge i_clk_sys);
		i_reg.rd <= 1'b0;
		#1 v = rdata;
	endtask
	task automatic fchk(input logic [2:0] i, input logic [31:0] e);
		@(posedge i_clk_sys);
		fidx <= i;
		@(posedge i_clk_sys);
		#1 check("filter word", fword, e);
	endtask

	// ****
	// scenarios
	// ****
	task automatic t_reset;
		rd(8'h24);
		check("tag1", v, 32'hffff);
		rd(8'h28);
		check("tag2", v, 32'hffff);
		rd(8'h30);
		check("wake ctl", v, 32'h0);
		rd(8'h40);
		check("unmapped", v, 32'h0);
	endtask
	task automatic t_length;
		int ln[6] = '{1522, 1523, 1538, 1539, 1519, 1518};
		logic [15:0] tg[6] = '{16'h8100, 16'h8100, 16'h88a8, 16'h88a8,
			16'h0800, 16'h0800};
		logic [2:0] ex[6] = '{3'b010, 3'b110, 3'b001, 3'b101, 3'b100,
			3'b000};
		wr(8'h24, 32'hffff8100);
		wr(8'h28, 32'h88a8);
		rd(8'h24);
		check("tag1 rw", v, 32'h8100);
		for (int i = 0; i < 6; i++) begin
			m_u.send(ln[i], tg[i], 1'b1, 3'b100);
			#1 check("done", res.done, 1'b1);
			check("tags", {res.tag1, res.tag2}, ex[i][1:0]);
			check("too long", res.too_long, ex[i][2]);
			check("length", res.len, ln[i][11:0]);
		end
		rd(8'h34);
		check("oversize irq", v, 32'h8);
		wr(8'h28, 32'h8100);
		m_u.send(1523, 16'h8100, 1'b1, 3'b100);
		#1 check("equal tags", {res.tag1, res.tag2}, 2'b10);
		check("equal limit", res.too_long, 1'b1);
	endtask
	task automatic t_wake;
		wr(8'h34, 32'hf);
		wr(8'h38, 32'hf);
		wr(8'h30, 32'h2);
		wr(8'h3c, 32'h1);
		rd(8'h3c);
		check("power save", v, 32'h1);
		m_u.send(64, 16'h0800, 1'b1, 3'b110);
		#1 check("magic wake", {wake, ps}, 2'b10);
		rd(8'h30);
		check("magic flag", v, 32'h22);
		check("irq on", irq, 1'b1);
		m_u.send(64, 16'h0800, 1'b1, 3'b100);
		rd(8'h30);
		check("flag sticks", v, 32'h22);
		wr(8'h34, 32'hf);
		wr(8'h30, 32'h22);
		rd(8'h30);
		check("flag clear", v, 32'h2);
		check("irq off", irq, 1'b0);
		wr(8'h30, 32'h0);
		m_u.send(64, 16'h0800, 1'b1, 3'b101);
		rd(8'h30);
		check("wake off", v, 32'h0);
		wr(8'h30, 32'h4);
		m_u.send(64, 16'h0800, 1'b1, 3'b111);
		rd(8'h30);
		check("wake frame", v, 32'h44);
		wr(8'h30, 32'h240);
		wr(8'h34, 32'hf);
		wr(8'h38, 32'h0);
		wr(8'h3c, 32'h1);
		m_u.send(64, 16'h0800, 1'b1, 3'b100);
		#1 check("group frame", {wake, ps}, 2'b01);
		m_u.send(64, 16'h0800, 1'b0, 3'b100);
		#1 check("unicast wake", {wake, ps}, 2'b10);
		rd(8'h30);
		check("unicast flag", v, 32'h240);
		check("irq masked", irq, 1'b0);
		wr(8'h38, 32'h4);
		rd(8'h34);
		check("irq status", v, 32'h4);
		check("irq unmasked", irq, 1'b1);
		wr(8'h34, 32'h4);
		rd(8'h34);
		check("status cleared", v, 32'h0);
		check("irq cleared", irq, 1'b0);
	endtask
	task automatic t_filter;
		for (int i = 0; i < 9; i++)
			wr(8'h2c, 32'ha0 + i);
		fchk(3'h0, 32'ha8);
		for (int i = 1; i < 8; i++)
			fchk(i[2:0], 32'ha0 + i);
		@(posedge i_clk_sys);
		i_soft_rst <= 1'b1;
		@(posedge i_clk_sys);
		i_soft_rst <= 1'b0;
		wr(8'h2c, 32'hbb);
		fchk(3'h0, 32'hbb);
		fchk(3'h1, 32'ha1);
		rd(8'h24);
		check("tag1 soft", v, 32'hffff);
		rd(8'h30);
		check("ctl soft", v, 32'h0);
	endtask

	initial forever #5 i_clk_sys = ~i_clk_sys;
	initial begin
		#500000;
		mismatches++;
		close_out;
	end
	initial begin
		repeat (12) @(posedge i_clk_sys);
		i_rst <= 1'b0;
		t_reset;
		t_length;
		t_wake;
		t_filter;
		close_out;
	end
endmodule
